// ### rtl/fwm_fault_warning_manager.sv
// Fault and warning manager: grading, reset requests, history and code outputs.
// Assumes one system clock; events, discrete inputs and parameter access are synchronous.
// Summary of operation
// - Grade every event into four severity classes.
// - Reset request by parameter write or input.
// - Class-1 resettable and class-2 need servo off.
// - Warnings clear without servo off.
// - Alarm clear input acts on valid edge.
// - Level mode forces edge, needs 3 ms hold.
// - Keep ten entries with code and snapshot.
// - Five recurrences stored as one entry.
// - Reset and init write both clear history.
// - Index selects entry, code, eight status words.
// - Empty history entry reads zero code.
// - Code packs class nibble over event code.
// - Three outputs carry most severe active event code.
// - Output logic sets electrical level of valid.
// - Non-resettable codes map to fixed output patterns.
// - Non-resettable faults survive every reset request.
// - Some settings apply only once servo stops.
// - Class-1 resettable codes follow same scheme.
`timescale 1ns/1ps

`include "fwm_regs.svh"

module fwm_fault_warning_manager #(
  parameter int HIST_DEPTH = 10,
  parameter int REPEAT_LIMIT = 5,
  parameter int CLK_MHZ = 50,
  parameter int RST_HOLD_CYC = `FWM_RST_HOLD_US * CLK_MHZ
) (
  input wire logic sys_clk, // System clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic clk_en, // Clock enable, freezes state when low.
  input wire logic evt_valid, // One-cycle pulse: an event occurs.
  input wire fwm_pkg::fwm_event_t evt, // Class and code of the event.
  input wire fwm_pkg::fwm_status_t evt_status, // Drive status at occurrence.
  input wire logic servo_enable, // Servo enable input, logically valid high.
  input wire logic alarm_clear_input, // Alarm clear discrete input, logical level.
  input wire logic reset_input_function, // Alarm clear function assigned to the input.
  input wire logic reset_in_high_speed, // The assigned input is a high-speed one.
  input wire logic reset_in_level_mode, // The assigned input is configured level valid.
  input wire logic code_out_bit1_function, // First code output assigned.
  input wire logic code_out_bit2_function, // Second code output assigned.
  input wire logic code_out_bit3_function, // Third code output assigned.
  input wire logic param_wr, // One-cycle parameter write strobe.
  input wire logic param_rd, // One-cycle parameter read strobe.
  input wire logic [7:0] param_addr, // Parameter number.
  input wire logic [15:0] param_wdata, // Parameter write value.
  output logic [15:0] param_rdata, // Parameter read value.
  output logic param_ack, // One-cycle answer to a strobe.
  output logic code_out_bit1, // First code output terminal level.
  output logic code_out_bit2, // Second code output terminal level.
  output logic code_out_bit3, // Third code output terminal level.
  output logic [3:0] class_active // Active flag per severity class.
);

  localparam int NCLS = 4;
  localparam int CW = $clog2(HIST_DEPTH + 1);
  localparam int IW = $clog2(HIST_DEPTH);
  localparam int RW = $clog2(REPEAT_LIMIT + 1);
  localparam int HW = $clog2(RST_HOLD_CYC + 1);

  function automatic logic [3:0] class_nibble(input fwm_pkg::fwm_class_t cls);
    case (cls)
      fwm_pkg::FWM_C1_NONRESET: class_nibble = `FWM_NIB_C1_NONRESET;
      fwm_pkg::FWM_C1_RESET: class_nibble = `FWM_NIB_C1_RESET;
      fwm_pkg::FWM_C2_RESET: class_nibble = `FWM_NIB_C2_RESET;
      default: class_nibble = `FWM_NIB_C3_WARN;
    endcase
  endfunction

  function automatic logic in_range(input logic [11:0] c, input logic [11:0] lo,
                                    input logic [11:0] hi);
    in_range = (c >= lo) && (c <= hi);
  endfunction

  // Maps an active event to its three-bit code, ordered third, second, first.
  // Events outside the table give 000.
  function automatic logic [2:0] code_map(input logic [1:0] cls, input logic [11:0] c);
    code_map = `FWM_OUT_000;
    if (cls == 2'(fwm_pkg::FWM_C1_NONRESET)) begin
      if (in_range(c, `FWM_C1N_GRP1_LO, `FWM_C1N_GRP1_HI) || c == `FWM_C1N_ENC_INTF) begin
        code_map = `FWM_OUT_111;
      end else if (in_range(c, `FWM_C1N_GRP2_LO, `FWM_C1N_GRP2_HI)) begin
        code_map = `FWM_OUT_110;
      end else if (in_range(c, `FWM_C1N_ENC_LO, `FWM_C1N_ENC_HI)) begin
        code_map = `FWM_OUT_010;
      end
    end else if (cls == 2'(fwm_pkg::FWM_C1_RESET)) begin
      if (c == `FWM_C1R_DUP_IN || c == `FWM_C1R_DO_LIMIT) begin
        code_map = `FWM_OUT_111;
      end else if (c == `FWM_C1R_DQ_OVF || c == `FWM_C1R_UNDERVOLT) begin
        code_map = `FWM_OUT_110;
      end else if (c == `FWM_C1R_OVERVOLT) begin
        code_map = `FWM_OUT_011;
      end
    end
  endfunction

  // Reset release through two flip-flops.
  // The synchroniser ignores clk_en so that a reset always ends.
  logic rst_s1_r;
  logic rst_n_r;
  always_ff @(posedge sys_clk or negedge nrst) begin
    if (!nrst) begin
      rst_s1_r <= 1'b0;
      rst_n_r <= 1'b0;
    end else begin
      rst_s1_r <= 1'b1;
      rst_n_r <= rst_s1_r;
    end
  end

  // Parameter decode.
  // Unmapped numbers decode to nothing; their writes are dropped but still answered.
  wire wr_fault_reset = param_wr && param_addr == `FWM_P_FAULT_RESET;
  wire wr_sys_init = param_wr && param_addr == `FWM_P_SYS_INIT;
  wire wr_hist_sel = param_wr && param_addr == `FWM_P_HIST_SEL;
  wire wr_out_logic = param_wr && param_addr == `FWM_P_OUT_LOGIC;
  wire stat_hit = param_addr >= `FWM_P_HIST_STAT0 && param_addr <= `FWM_P_HIST_STAT_LAST;
  wire [2:0] stat_idx = 3'(param_addr - `FWM_P_HIST_STAT0);

  // Alarm clear input filter. Starting in the wait state means a level already
  // valid at reset release is not taken as a request.
  // The hold counter restarts from zero whenever the input drops before the span
  // ends, so a short glitch never accumulates towards a request.
  fwm_pkg::fwm_rf_state_t rf_state_r;
  fwm_pkg::fwm_rf_state_t rf_state_nxt;
  logic [HW-1:0] hold_cnt_r;
  logic [HW-1:0] hold_cnt_nxt;
  logic din_req_nxt;
  wire din_valid = alarm_clear_input && reset_input_function && !reset_in_high_speed;
  wire hold_done = hold_cnt_r == HW'(RST_HOLD_CYC - 1);

  always_comb begin
    rf_state_nxt = rf_state_r;
    hold_cnt_nxt = hold_cnt_r;
    din_req_nxt = 1'b0;
    case (rf_state_r)
      fwm_pkg::FWM_RF_IDLE: begin
        hold_cnt_nxt = '0;
        if (din_valid && reset_in_level_mode) begin
          rf_state_nxt = fwm_pkg::FWM_RF_HOLD;
        end else if (din_valid) begin
          din_req_nxt = 1'b1;
          rf_state_nxt = fwm_pkg::FWM_RF_WAIT_LOW;
        end
      end
      fwm_pkg::FWM_RF_HOLD: begin
        if (!din_valid) begin
          rf_state_nxt = fwm_pkg::FWM_RF_IDLE;
        end else if (hold_done) begin
          din_req_nxt = 1'b1;
          rf_state_nxt = fwm_pkg::FWM_RF_WAIT_LOW;
        end else begin
          hold_cnt_nxt = HW'(hold_cnt_r + 1'b1);
        end
      end
      fwm_pkg::FWM_RF_WAIT_LOW: begin
        if (!din_valid) begin
          rf_state_nxt = fwm_pkg::FWM_RF_IDLE;
        end
      end
      default: rf_state_nxt = fwm_pkg::FWM_RF_WAIT_LOW;
    endcase
  end

  logic din_req_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      rf_state_r <= fwm_pkg::FWM_RF_WAIT_LOW;
      hold_cnt_r <= '0;
      din_req_r <= 1'b0;
    end else if (clk_en) begin
      rf_state_r <= rf_state_nxt;
      hold_cnt_r <= hold_cnt_nxt;
      din_req_r <= din_req_nxt;
    end
  end

  // Reset requests and per-class clears. Class 0 has no clear term at all, so
  // nothing can remove a non-resettable fault short of a full reset. The servo
  // test looks at the level in the request cycle itself.
  wire reset_req = din_req_r || (wr_fault_reset && param_wdata == `FWM_RESET_CMD);
  wire servo_off_clr = reset_req && !servo_enable;
  wire [NCLS-1:0] class_clr = {reset_req, servo_off_clr, servo_off_clr, 1'b0};

  // Active events per class; a new event wins over a clear in the same cycle.
  // Each class keeps only its latest code.
  logic [NCLS-1:0] active_r;
  logic [11:0] act_code_r [NCLS];
  wire [NCLS-1:0] class_set;
  genvar gc;
  generate
    for (gc = 0; gc < NCLS; gc++) begin : g_class
      assign class_set[gc] = evt_valid && evt.cls == fwm_pkg::fwm_class_t'(gc);
      always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          active_r[gc] <= 1'b0;
          act_code_r[gc] <= '0;
        end else if (clk_en) begin
          active_r[gc] <= class_set[gc] || (active_r[gc] && !class_clr[gc]);
          if (class_set[gc]) begin
            act_code_r[gc] <= evt.code;
          end
        end
      end
    end
  endgenerate

  // History: entry 0 is the newest. A recurrence of the newest code bumps a counter
  // until REPEAT_LIMIT occurrences share one slot, then takes a new one. Shifting all entries on a
  // push keeps the read side a plain index with no pointer arithmetic.
  logic [15:0] hist_code_r [HIST_DEPTH];
  fwm_pkg::fwm_status_t hist_stat_r [HIST_DEPTH];
  logic [CW-1:0] hist_cnt_r;
  logic [CW-1:0] hist_cnt_nxt;
  logic [RW-1:0] rep_cnt_r;
  logic [RW-1:0] rep_cnt_nxt;
  wire [15:0] evt_packed = {class_nibble(evt.cls), evt.code};
  wire hist_clr = wr_sys_init &&
                  (param_wdata == `FWM_INIT_CMD_A || param_wdata == `FWM_INIT_CMD_B);
  wire dup = evt_valid && !hist_clr && hist_cnt_r != '0 && hist_code_r[0] == evt_packed &&
             rep_cnt_r < RW'(REPEAT_LIMIT - 1);
  wire push = evt_valid && !dup;
  wire hist_full = hist_cnt_r == CW'(HIST_DEPTH);

  assign hist_cnt_nxt = hist_clr ? CW'(push) :
                        (push && !hist_full) ? CW'(hist_cnt_r + 1'b1) : hist_cnt_r;
  assign rep_cnt_nxt = (push || hist_clr) ? '0 : dup ? RW'(rep_cnt_r + 1'b1) : rep_cnt_r;

  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      hist_cnt_r <= '0;
      rep_cnt_r <= '0;
    end else if (clk_en) begin
      hist_cnt_r <= hist_cnt_nxt;
      rep_cnt_r <= rep_cnt_nxt;
    end
  end

  genvar gh;
  generate
    for (gh = 0; gh < HIST_DEPTH; gh++) begin : g_hist
      always_ff @(posedge sys_clk or negedge rst_n_r) begin
        if (!rst_n_r) begin
          hist_code_r[gh] <= '0;
          hist_stat_r[gh] <= '0;
        end else if (clk_en && push) begin
          hist_code_r[gh] <= (gh == 0) ? evt_packed : hist_code_r[(gh == 0) ? 0 : gh - 1];
          hist_stat_r[gh] <= (gh == 0) ? evt_status : hist_stat_r[(gh == 0) ? 0 : gh - 1];
        end
      end
    end
  endgenerate

  // Software registers. Output logic takes effect only while the servo is off.
  // The fault reset value is kept as written; software writes 0 back itself.
  logic [15:0] fault_reset_r;
  logic [15:0] hist_sel_r;
  logic [2:0] out_logic_pend_r;
  logic [2:0] out_logic_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      fault_reset_r <= `FWM_RST_FAULT_RESET;
      hist_sel_r <= `FWM_RST_HIST_SEL;
      out_logic_pend_r <= `FWM_RST_OUT_LOGIC;
      out_logic_r <= `FWM_RST_OUT_LOGIC;
    end else if (clk_en) begin
      if (wr_fault_reset) begin
        fault_reset_r <= param_wdata;
      end
      if (wr_hist_sel) begin
        hist_sel_r <= param_wdata;
      end
      if (wr_out_logic) begin
        out_logic_pend_r <= param_wdata[2:0];
      end
      if (!servo_enable) begin
        out_logic_r <= out_logic_pend_r;
      end
    end
  end

  // Read selection. An index at or beyond the stored count reads as zero,
  // just like an empty history.
  wire hsel_ok = hist_sel_r < 16'(hist_cnt_r);
  wire [IW-1:0] hsel_idx = hist_sel_r[IW-1:0];
  wire [15:0] sel_code = hsel_ok ? hist_code_r[hsel_idx] : 16'h0000;
  wire [15:0] sel_stat = hsel_ok ? hist_stat_r[hsel_idx][stat_idx] : 16'h0000;
  wire [15:0] rd_data_w =
    (param_addr == `FWM_P_FAULT_RESET) ? fault_reset_r :
    (param_addr == `FWM_P_HIST_SEL) ? hist_sel_r :
    (param_addr == `FWM_P_HIST_CODE) ? sel_code :
    stat_hit ? sel_stat :
    (param_addr == `FWM_P_OUT_LOGIC) ? {13'h0000, out_logic_pend_r} : 16'h0000;

  // Every strobe taken while clk_en is high is answered one cycle later, mapped or not, so the host never waits.
  logic [15:0] param_rdata_r;
  logic param_ack_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      param_rdata_r <= 16'h0000;
      param_ack_r <= 1'b0;
    end else if (clk_en) begin
      param_ack_r <= param_rd || param_wr;
      if (param_rd) begin
        param_rdata_r <= rd_data_w;
      end
    end
  end

  // Code output of the most severe active class.
  // An unassigned output stays at 0 whatever its output logic says.
  wire [1:0] top_cls = active_r[0] ? 2'h0 : active_r[1] ? 2'h1 : active_r[2] ? 2'h2 : 2'h3;
  wire [2:0] code_logical = (|active_r) ? code_map(top_cls, act_code_r[top_cls]) :
                            `FWM_OUT_000;
  wire [2:0] out_func = {code_out_bit3_function, code_out_bit2_function, code_out_bit1_function};
  wire [2:0] code_level_nxt = out_func & (code_logical ^ out_logic_r);

  logic [2:0] code_level_r;
  logic [3:0] class_active_r;
  always_ff @(posedge sys_clk or negedge rst_n_r) begin
    if (!rst_n_r) begin
      code_level_r <= 3'h0;
      class_active_r <= 4'h0;
    end else if (clk_en) begin
      code_level_r <= code_level_nxt;
      class_active_r <= active_r;
    end
  end

  assign param_rdata = param_rdata_r;
  assign param_ack = param_ack_r;
  assign code_out_bit1 = code_level_r[0];
  assign code_out_bit2 = code_level_r[1];
  assign code_out_bit3 = code_level_r[2];
  assign class_active = class_active_r;

endmodule

// ### rtl/fwm_regs.svh
// Parameter numbers, reset values, class nibbles, timing and code table bounds.
// Assumes it is included by bare name wherever these constants are needed.
`ifndef FWM_REGS_SVH
`define FWM_REGS_SVH

`define FWM_P_FAULT_RESET 8'h00
`define FWM_P_SYS_INIT 8'h01
`define FWM_P_HIST_SEL 8'h02
`define FWM_P_HIST_CODE 8'h03
`define FWM_P_HIST_STAT0 8'h04
`define FWM_P_HIST_STAT_LAST 8'h0B
`define FWM_P_OUT_LOGIC 8'h0C

`define FWM_RST_FAULT_RESET 16'h0000
`define FWM_RST_HIST_SEL 16'h0000
`define FWM_RST_OUT_LOGIC 3'h0

`define FWM_RESET_CMD 16'h0001
`define FWM_INIT_CMD_A 16'h0001
`define FWM_INIT_CMD_B 16'h0002

`define FWM_NIB_C1_NONRESET 4'h0
`define FWM_NIB_C1_RESET 4'h2
`define FWM_NIB_C2_RESET 4'h6
`define FWM_NIB_C3_WARN 4'hE

`define FWM_RST_HOLD_US 3000

`define FWM_C1N_GRP1_LO 12'h101
`define FWM_C1N_GRP1_HI 12'h136
`define FWM_C1N_ENC_INTF 12'h740
`define FWM_C1N_GRP2_LO 12'h201
`define FWM_C1N_GRP2_HI 12'h234
`define FWM_C1N_ENC_LO 12'hA33
`define FWM_C1N_ENC_HI 12'hA35
`define FWM_C1R_DUP_IN 12'h130
`define FWM_C1R_DO_LIMIT 12'h131
`define FWM_C1R_DQ_OVF 12'h207
`define FWM_C1R_OVERVOLT 12'h400
`define FWM_C1R_UNDERVOLT 12'h410

`define FWM_OUT_111 3'h7
`define FWM_OUT_110 3'h6
`define FWM_OUT_011 3'h3
`define FWM_OUT_010 3'h2
`define FWM_OUT_000 3'h0

`endif

// ### rtl/fwm_pkg.sv
// Types shared by the fault and warning manager.
// Assumes the constants of fwm_regs.svh for numeric values.
package fwm_pkg;

  typedef enum logic [1:0] {
    FWM_C1_NONRESET,
    FWM_C1_RESET,
    FWM_C2_RESET,
    FWM_C3_WARN
  } fwm_class_t;

  typedef struct packed {
    fwm_class_t cls;
    logic [11:0] code;
  } fwm_event_t;

  typedef logic [7:0][15:0] fwm_status_t;

  typedef enum logic [1:0] {
    FWM_RF_IDLE,
    FWM_RF_HOLD,
    FWM_RF_WAIT_LOW
  } fwm_rf_state_t;

endpackage

// ### testbench/fwm_host_model.sv
// Host motion controller model driving servo enable and the alarm clear input.
// Assumes bench task calls; it moves just after a rising edge of sys_clk.
`timescale 1ns/1ps
module fwm_host_model (
  input wire logic sys_clk, // System clock.
  output logic servo_enable, // Servo-on command, valid high.
  output logic alarm_clear_input // Alarm clear discrete, valid high.
);
  initial begin
    servo_enable = 1'b0;
    alarm_clear_input = 1'b0;
  end
  task automatic servo(input logic v);
    @(posedge sys_clk) #1;
    servo_enable = v;
  endtask
  task automatic level(input logic v);
    @(posedge sys_clk) #1;
    alarm_clear_input = v;
  endtask
  // Edge inputs need one cycle; level-valid inputs need more than the filter span.
  task automatic press(input int n);
    level(1'b1);
    repeat (n - 1) @(posedge sys_clk);
    level(1'b0);
  endtask
endmodule

// ### testbench/fwm_checker_assertions.sv
// Concurrent checks on the ports of the fault and warning manager.
// Assumes one clock domain and the constants of fwm_regs.svh.
`timescale 1ns/1ps
`include "fwm_regs.svh"
module fwm_checker (
  input wire logic sys_clk, // Clock.
  input wire logic nrst, // Reset, active low.
  input wire logic clk_en, // Clock enable.
  input wire logic evt_valid, // Event strobe.
  input wire fwm_pkg::fwm_event_t evt, // Event.
  input wire logic servo_enable, // Servo on.
  input wire logic alarm_clear_input, // Alarm clear.
  input wire logic reset_in_high_speed, // Input is high-speed.
  input wire logic param_wr, // Write strobe.
  input wire logic param_rd, // Read strobe.
  input wire logic [7:0] param_addr, // Parameter number.
  input wire logic [15:0] param_wdata, // Write value.
  input wire logic [15:0] param_rdata, // Read value.
  input wire logic param_ack, // Answer.
  input wire logic [3:0] class_active // Active classes.
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst);
  sequence clr_held;
    alarm_clear_input [*4];
  endsequence
  sequence lone_strobe;
    (clk_en && (param_wr || param_rd)) ##1 (clk_en && !(param_wr || param_rd));
  endsequence
  sequence reset_write;
    clk_en && param_wr && param_addr == `FWM_P_FAULT_RESET && param_wdata == `FWM_RESET_CMD;
  endsequence
  ack_pulse_a: assert property (lone_strobe |-> param_ack ##1 !param_ack)
    else $error("param_ack is not a one-cycle answer");
  rdata_hold_a: assert property (!param_rd |=> $stable(param_rdata))
    else $error("param_rdata changed without a read");
  evt_flag_a: assert property (evt_valid && clk_en |-> ##2 class_active[$past(evt.cls, 2)])
    else $error("event class not flagged");
  nonreset_keep_a: assert property (class_active[0] |=> class_active[0])
    else $error("non-resettable fault cleared");
  servo_gate_a: assert property (
    class_active[1] && servo_enable && $past(servo_enable) && $past(servo_enable, 2)
    |=> class_active[1]) else $error("class-1 fault cleared with servo on");
  warn_clear_a: assert property (reset_write |-> ##[1:3] !class_active[3])
    else $error("warning kept after reset write");
  edge_only_a: assert property (clr_held ##0 $rose(class_active[3]) |=> class_active[3])
    else $error("held clear level removed a warning");
  fast_input_a: assert property (
    reset_in_high_speed && class_active[3] && !param_wr && !$past(param_wr)
    |=> class_active[3]) else $error("high-speed input cleared a warning");
endmodule
bind fwm_fault_warning_manager fwm_checker fwm_checker_i (.sys_clk, .nrst, .clk_en, .evt_valid, .evt,
  .servo_enable, .alarm_clear_input, .reset_in_high_speed, .param_wr, .param_rd, .param_addr,
  .param_wdata, .param_rdata, .param_ack, .class_active);

// ### testbench/tb_fault_warning_manager.sv
// Self-checking bench for the fault and warning manager.
// Assumes the host model drives servo enable and the alarm clear input.
`timescale 1ns/1ps
`include "fwm_regs.svh"
module tb_fault_warning_manager;
  logic sys_clk, nrst, clk_en, evt_valid, param_wr, param_rd, param_ack;
  logic [2:0] out_fn;
  logic reset_input_function, reset_in_high_speed, reset_in_level_mode;
  logic code_out_bit1, code_out_bit2, code_out_bit3;
  logic [7:0] param_addr;
  logic [15:0] param_wdata, param_rdata;
  logic [3:0] class_active;
  fwm_pkg::fwm_event_t evt;
  fwm_pkg::fwm_status_t evt_status;
  wire logic servo_enable, alarm_clear_input;
  wire logic [2:0] outs = {code_out_bit3, code_out_bit2, code_out_bit1};
  int errors, checks_done;
  logic [3:0] nib [4] = '{`FWM_NIB_C1_NONRESET, `FWM_NIB_C1_RESET, `FWM_NIB_C2_RESET,
    `FWM_NIB_C3_WARN};
  localparam logic [1:0] TC [9] = '{0, 0, 0, 0, 0, 0, 0, 1, 1};
  localparam logic [11:0] TK [9] = '{12'h101, 12'h136, 12'h740, 12'h201, 12'h234, 12'hA33,
    12'hA35, 12'h130, 12'h400};
  localparam logic [2:0] TO [9] = '{7, 7, 7, 6, 6, 2, 2, 7, 3};

  fwm_fault_warning_manager #(.RST_HOLD_CYC(8)) fwm_fault_warning_manager_i (.sys_clk, .nrst,
    .clk_en, .evt_valid, .evt, .evt_status, .servo_enable, .alarm_clear_input,
    .reset_input_function, .reset_in_high_speed, .reset_in_level_mode,
    .code_out_bit1_function(out_fn[0]), .code_out_bit2_function(out_fn[1]),
    .code_out_bit3_function(out_fn[2]), .param_wr, .param_rd, .param_addr, .param_wdata,
    .param_rdata, .param_ack, .code_out_bit1, .code_out_bit2, .code_out_bit3, .class_active);
  fwm_host_model fwm_host_model_i (.sys_clk, .servo_enable, .alarm_clear_input);

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic acc(input logic w, input logic [7:0] a, input logic [15:0] d);
    cyc(1);
    param_wr = w;
    param_rd = !w;
    param_addr = a;
    param_wdata = d;
    cyc(1);
    param_wr = 1'b0;
    param_rd = 1'b0;
    check({15'h0, param_ack}, 16'h0001);
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    acc(1'b0, a, 16'h0000);
    check(param_rdata, e);
  endtask
  task automatic ev(input logic [1:0] c, input logic [11:0] k);
    cyc(1);
    evt_valid = 1'b1;
    evt = {c, k};
    for (int i = 0; i < 8; i++) evt_status[i] = {i[3:0], k};
    cyc(1);
    evt_valid = 1'b0;
    cyc(3);
  endtask
  task automatic do_reset();
    nrst = 1'b0;
    cyc(12);
    nrst = 1'b1;
    cyc(3);
  endtask
  task automatic print_verdict();
    $display("checks %0d, errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic t_regs();
    rd(`FWM_P_FAULT_RESET, `FWM_RST_FAULT_RESET);
    rd(`FWM_P_HIST_CODE, 16'h0000);
    rd(8'h7F, 16'h0000);
    acc(1'b1, `FWM_P_HIST_SEL, 16'h0003);
    rd(`FWM_P_HIST_SEL, 16'h0003);
  endtask
  task automatic t_classes();
    fwm_host_model_i.servo(1'b1);
    for (int c = 0; c < 4; c++) ev(c[1:0], 12'h101 + 12'(c));
    check({12'h0, class_active}, 16'h000F);
    check({13'h0, outs}, {13'h0, `FWM_OUT_111});
    for (int i = 0; i < 4; i++) begin
      acc(1'b1, `FWM_P_HIST_SEL, 16'(i));
      rd(`FWM_P_HIST_CODE, {nib[3 - i], 12'h104 - 12'(i)});
    end
    rd(`FWM_P_HIST_STAT0, 16'h0101);
    rd(`FWM_P_HIST_STAT_LAST, 16'h7101);
    acc(1'b1, `FWM_P_FAULT_RESET, `FWM_RESET_CMD);
    cyc(3);
    check({12'h0, class_active}, 16'h0007);
    fwm_host_model_i.servo(1'b0);
    fwm_host_model_i.press(2);
    cyc(4);
    check({12'h0, class_active}, 16'h0001);
    rd(`FWM_P_HIST_CODE, 16'h0101);
    acc(1'b1, `FWM_P_FAULT_RESET, 16'h0000);
  endtask
  task automatic t_codes();
    for (int i = 0; i < 9; i++) begin
      do_reset();
      ev(TC[i], TK[i]);
      check({13'h0, outs}, {13'h0, TO[i]});
    end
    out_fn = 3'b101;
    cyc(3);
    check({13'h0, outs}, 16'h0001);
    out_fn = 3'b111;
    fwm_host_model_i.servo(1'b1);
    acc(1'b1, `FWM_P_OUT_LOGIC, 16'h0007);
    cyc(3);
    check({13'h0, outs}, 16'h0003);
    fwm_host_model_i.servo(1'b0);
    cyc(3);
    check({13'h0, outs}, 16'h0004);
  endtask
  task automatic t_input();
    do_reset();
    fwm_host_model_i.level(1'b1);
    cyc(4);
    ev(2'h3, 12'h900);
    check({15'h0, class_active[3]}, 16'h0001);
    fwm_host_model_i.level(1'b0);
    reset_in_level_mode = 1'b1;
    fwm_host_model_i.press(3);
    cyc(4);
    check({15'h0, class_active[3]}, 16'h0001);
    fwm_host_model_i.press(12);
    cyc(4);
    check({15'h0, class_active[3]}, 16'h0000);
    reset_in_level_mode = 1'b0;
    reset_in_high_speed = 1'b1;
    ev(2'h3, 12'h901);
    fwm_host_model_i.press(2);
    cyc(4);
    check({15'h0, class_active[3]}, 16'h0001);
    reset_in_high_speed = 1'b0;
    reset_input_function = 1'b0;
    fwm_host_model_i.press(2);
    cyc(4);
    check({15'h0, class_active[3]}, 16'h0001);
    reset_input_function = 1'b1;
    clk_en = 1'b0;
    ev(2'h2, 12'h555);
    clk_en = 1'b1;
    cyc(3);
    check({15'h0, class_active[2]}, 16'h0000);
  endtask
  task automatic t_hist();
    acc(1'b1, `FWM_P_SYS_INIT, `FWM_INIT_CMD_B);
    acc(1'b1, `FWM_P_HIST_SEL, 16'h0000);
    rd(`FWM_P_HIST_CODE, 16'h0000);
    for (int i = 0; i < 11; i++) ev(2'h3, 12'h900 + 12'(i));
    rd(`FWM_P_HIST_CODE, 16'hE90A);
    acc(1'b1, `FWM_P_HIST_SEL, 16'h0009);
    rd(`FWM_P_HIST_STAT_LAST, 16'h7901);
    acc(1'b1, `FWM_P_HIST_SEL, 16'h000A);
    rd(`FWM_P_HIST_CODE, 16'h0000);
    acc(1'b1, `FWM_P_SYS_INIT, `FWM_INIT_CMD_A);
    acc(1'b1, `FWM_P_HIST_SEL, 16'h0001);
    for (int i = 0; i < 6; i++) begin
      ev(2'h2, 12'h321);
      rd(`FWM_P_HIST_CODE, (i < 5) ? 16'h0000 : 16'h6321);
    end
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial begin
    {nrst, evt_valid, param_wr, param_rd, reset_in_high_speed, reset_in_level_mode} = '0;
    {clk_en, reset_input_function, out_fn} = 5'h1F;
    {evt, evt_status, param_addr, param_wdata} = '0;
    errors = 0;
    checks_done = 0;
    do_reset();
    t_regs();
    t_classes();
    t_codes();
    t_input();
    t_hist();
    print_verdict();
  end
  initial begin
    cyc(20000);
    errors++;
    print_verdict();
  end
endmodule
